/* rtl/aalu_pkg.sv */
// Constants, encodings and carrier types for the accumulator execution unit.
package aalu_pkg;

    // ======================================================================
    // Widths
    // ======================================================================
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSTR_W = 14;

    // ======================================================================
    // Instruction field positions
    // ======================================================================
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int BITSEL_HI = 9;
    localparam int BITSEL_LO = 7;
    localparam int FADDR_HI = 6;
    localparam int DIGIT_BIT = 4;

    // ======================================================================
    // Instruction classes and sub-opcodes
    // ======================================================================
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] CLASS_LIT = 2'h3;
    localparam logic [3:0] OPC_ADD_RF = 4'h7;
    localparam logic [3:0] OPC_AND_RF = 4'h5;
    localparam logic [3:0] OPC_OR_RF = 4'h4;
    localparam logic [3:0] OPC_MOV_RF = 4'h8;
    localparam logic [3:0] OPC_MISC = 4'h0;
    localparam logic [1:0] OPC_BCLR = 2'h0;
    localparam logic [1:0] OPC_BSET = 2'h1;
    localparam logic [2:0] OPC_ADDL = 3'h7;
    localparam logic [3:0] OPC_ANDL = 4'h9;
    localparam logic [3:0] OPC_IORL = 4'h8;
    localparam logic [1:0] OPC_MOVL = 2'h0;
    // Low five bits of the no-operation form; bits 6:5 are ignored.
    localparam logic [4:0] NOP_LOW = 5'h00;

    // ======================================================================
    // Reset values
    // ======================================================================
    localparam logic [7:0] ACC_RST = 8'h00;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic [3:0] {
        AALU_OP_NONE = 4'h0,
        AALU_OP_ADDL = 4'h1,
        AALU_OP_ANDL = 4'h2,
        AALU_OP_IORL = 4'h3,
        AALU_OP_MOVL = 4'h4,
        AALU_OP_ADDF = 4'h5,
        AALU_OP_ANDF = 4'h6,
        AALU_OP_IORF = 4'h7,
        AALU_OP_MOVR = 4'h8,
        AALU_OP_STOR = 4'h9,
        AALU_OP_BCLR = 4'ha,
        AALU_OP_BSET = 4'hb,
        AALU_OP_NOP = 4'hc,
        AALU_OP_BAD = 4'hd
    } aalu_op_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } aalu_flags_t;

    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } aalu_rf_wr_t;

endpackage

/* rtl/aalu_core.sv */
// Execution datapath for the literal, register and bit instruction subset.
//
// Function
// [RULE1] Literal add writes acc plus immediate to acc and updates all flags.
// [RULE2] Register AND goes to the chosen destination and updates zero only.
// [RULE3] Destination bit 0 selects acc and 1 selects the addressed register.
// [RULE4] Register add goes to the chosen destination and updates all flags.
// [RULE5] Bit clear zeroes one bit of the register and leaves the flags.
// [RULE6] Bit set makes one bit of the register one and leaves the flags.
// [RULE7] Literal AND of acc and immediate goes to acc, updating zero only.
// [RULE8] Literal OR of acc and immediate goes to acc, updating zero only.
// [RULE9] Register OR goes to the chosen destination and updates zero only.
// [RULE10] Load literal (11 00xx) copies the immediate to acc; flags stay.
// [RULE11] Store copies acc to the register at the 7-bit address; flags stay.
// [RULE12] Register move copies the addressed register to the destination.
// [RULE13] Register move updates zero even when it writes back onto itself.
// [RULE14] 00 0000 0xx0 0000 is a no-operation whatever the free bits hold.
// [RULE15] A read-modify-write of a port register uses the pin levels.
// [RULE16] Zero marks a zero result; carry leaves bit 7, digit carry bit 3.
// [RULE17] Don't-care bits of the literal-load encoding are ignored.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps

module aalu_core #(
    parameter int DW = aalu_pkg::DATA_W,
    parameter int AW = aalu_pkg::ADDR_W,
    parameter int IW = aalu_pkg::INSTR_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Instruction from the decoder.
    input wire logic instr_valid_i,
    input wire logic [IW-1:0] instr_i,
    // Register file read port.
    output logic [AW-1:0] rf_raddr_o,
    input wire logic [DW-1:0] rf_rdata_i,
    input wire logic rf_is_port_i,
    // Port pin levels, asynchronous to the core clock.
    input wire logic [DW-1:0] pin_level_i,
    // Register file write port.
    output logic rf_we_o,
    output logic [AW-1:0] rf_waddr_o,
    output logic [DW-1:0] rf_wdata_o,
    // Architectural state.
    output logic [DW-1:0] acc_o,
    output logic carry_o,
    output logic digit_carry_flag_o,
    output logic zero_o,
    // Status.
    output logic done_o,
    output logic unsupported_o
);

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Each pin passes three flops; the sampled level only moves once the
    // second and third stages agree, which filters a single-cycle glitch.
    logic [DW-1:0] pin_s1_q;
    logic [DW-1:0] pin_s2_q;
    logic [DW-1:0] pin_s3_q;
    logic [DW-1:0] pin_lvl_q;
    logic [DW-1:0] pin_s1_d;
    logic [DW-1:0] pin_s2_d;
    logic [DW-1:0] pin_s3_d;
    logic [DW-1:0] pin_lvl_d;

    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_pin
            always_comb begin
                pin_s1_d[gi] = pin_level_i[gi];
                pin_s2_d[gi] = pin_s1_q[gi];
                pin_s3_d[gi] = pin_s2_q[gi];
                if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_lvl_d[gi] = pin_s3_q[gi];
                end else begin
                    pin_lvl_d[gi] = pin_lvl_q[gi];
                end
            end

            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                    pin_lvl_q[gi] <= 1'b0;
                end else begin
                    pin_s1_q[gi] <= pin_s1_d[gi];
                    pin_s2_q[gi] <= pin_s2_d[gi];
                    pin_s3_q[gi] <= pin_s3_d[gi];
                    pin_lvl_q[gi] <= pin_lvl_d[gi];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Decode
    // ======================================================================
    aalu_pkg::aalu_op_t op;
    logic [1:0] cls;
    logic [3:0] opc;
    logic dest_reg;
    logic [2:0] bit_sel;
    logic [AW-1:0] faddr;
    logic [DW-1:0] imm;

    assign cls = instr_i[aalu_pkg::CLASS_HI:aalu_pkg::CLASS_LO];
    assign opc = instr_i[aalu_pkg::OPC_HI:aalu_pkg::OPC_LO];
    assign dest_reg = instr_i[aalu_pkg::DEST_BIT];
    assign bit_sel = instr_i[aalu_pkg::BITSEL_HI:aalu_pkg::BITSEL_LO];
    assign faddr = instr_i[aalu_pkg::FADDR_HI:0];
    assign imm = instr_i[DW-1:0];

    always_comb begin
        op = aalu_pkg::AALU_OP_NONE;
        if (instr_valid_i) begin
            op = aalu_pkg::AALU_OP_BAD;
            case (cls)
                aalu_pkg::CLASS_BYTE: begin
                    case (opc)
                        aalu_pkg::OPC_ADD_RF: op = aalu_pkg::AALU_OP_ADDF;
                        aalu_pkg::OPC_AND_RF: op = aalu_pkg::AALU_OP_ANDF;
                        aalu_pkg::OPC_OR_RF: op = aalu_pkg::AALU_OP_IORF;
                        aalu_pkg::OPC_MOV_RF: op = aalu_pkg::AALU_OP_MOVR;
                        aalu_pkg::OPC_MISC: begin
                            if (dest_reg) begin
                                op = aalu_pkg::AALU_OP_STOR;
                            end else if (instr_i[4:0] == aalu_pkg::NOP_LOW)
                            begin
                                op = aalu_pkg::AALU_OP_NOP; // RULE14
                            end
                        end
                        default: op = aalu_pkg::AALU_OP_BAD;
                    endcase
                end
                aalu_pkg::CLASS_BIT: begin
                    case (opc[3:2])
                        aalu_pkg::OPC_BCLR: op = aalu_pkg::AALU_OP_BCLR;
                        aalu_pkg::OPC_BSET: op = aalu_pkg::AALU_OP_BSET;
                        default: op = aalu_pkg::AALU_OP_BAD;
                    endcase
                end
                aalu_pkg::CLASS_LIT: begin
                    if (opc[3:1] == aalu_pkg::OPC_ADDL) begin
                        op = aalu_pkg::AALU_OP_ADDL;
                    end else if (opc == aalu_pkg::OPC_ANDL) begin
                        op = aalu_pkg::AALU_OP_ANDL;
                    end else if (opc == aalu_pkg::OPC_IORL) begin
                        op = aalu_pkg::AALU_OP_IORL;
                    end else if (opc[3:2] == aalu_pkg::OPC_MOVL) begin
                        op = aalu_pkg::AALU_OP_MOVL; // RULE17
                    end
                end
                default: op = aalu_pkg::AALU_OP_BAD;
            endcase
        end
    end

    // ======================================================================
    // Operand fetch
    // ======================================================================
    logic [DW-1:0] acc_q;
    logic [DW-1:0] acc_d;
    aalu_pkg::aalu_flags_t flags_q;
    aalu_pkg::aalu_flags_t flags_d;
    aalu_pkg::aalu_rf_wr_t wr_q;
    aalu_pkg::aalu_rf_wr_t wr_d;
    logic done_q;
    logic done_d;
    logic bad_q;
    logic bad_d;
    logic [DW-1:0] fval;

    assign rf_raddr_o = faddr;

    // The write of the previous instruction reaches the register file one
    // cycle late, so a back-to-back read of that address is forwarded here.
    // Ports are exempt: their operand is always the pin level.
    always_comb begin
        if (rf_is_port_i) begin
            fval = pin_lvl_q; // RULE15
        end else if (wr_q.en && wr_q.addr == faddr) begin
            fval = wr_q.data;
        end else begin
            fval = rf_rdata_i;
        end
    end

    // ======================================================================
    // Execute
    // ======================================================================
    logic [DW-1:0] opnd_b;
    logic [DW:0] sum;
    logic [4:0] low_sum;
    logic [DW-1:0] res;
    logic upd_cdc;
    logic upd_z;
    logic to_reg;

    always_comb begin
        if (op == aalu_pkg::AALU_OP_ADDL) begin
            opnd_b = imm;
        end else begin
            opnd_b = fval;
        end
        sum = {1'b0, acc_q} + {1'b0, opnd_b}; // RULE16
        low_sum = {1'b0, acc_q[3:0]} + {1'b0, opnd_b[3:0]};
    end

    always_comb begin
        res = acc_q;
        upd_cdc = 1'b0;
        upd_z = 1'b0;
        to_reg = 1'b0;
        case (op)
            aalu_pkg::AALU_OP_ADDL: begin
                res = sum[DW-1:0]; // RULE1
                upd_cdc = 1'b1;
                upd_z = 1'b1;
            end
            aalu_pkg::AALU_OP_ANDL: begin
                res = acc_q & imm; // RULE7
                upd_z = 1'b1;
            end
            aalu_pkg::AALU_OP_IORL: begin
                res = acc_q | imm; // RULE8
                upd_z = 1'b1;
            end
            aalu_pkg::AALU_OP_MOVL: begin
                res = imm; // RULE10
            end
            aalu_pkg::AALU_OP_ADDF: begin
                res = sum[DW-1:0]; // RULE4
                upd_cdc = 1'b1;
                upd_z = 1'b1;
                to_reg = dest_reg;
            end
            aalu_pkg::AALU_OP_ANDF: begin
                res = acc_q & fval; // RULE2
                upd_z = 1'b1;
                to_reg = dest_reg;
            end
            aalu_pkg::AALU_OP_IORF: begin
                res = acc_q | fval; // RULE9
                upd_z = 1'b1;
                to_reg = dest_reg;
            end
            aalu_pkg::AALU_OP_MOVR: begin
                res = fval; // RULE12
                upd_z = 1'b1; // RULE13
                to_reg = dest_reg;
            end
            aalu_pkg::AALU_OP_STOR: begin
                res = acc_q; // RULE11
                to_reg = 1'b1;
            end
            aalu_pkg::AALU_OP_BCLR: begin
                res = fval & ~(8'h01 << bit_sel); // RULE5
                to_reg = 1'b1;
            end
            aalu_pkg::AALU_OP_BSET: begin
                res = fval | (8'h01 << bit_sel); // RULE6
                to_reg = 1'b1;
            end
            default: begin
                res = acc_q;
            end
        endcase
    end

    // ======================================================================
    // Write-back
    // ======================================================================
    // No-operation and unsupported words fall to the defaults below, so the
    // accumulator, flags and register file are all left untouched.
    always_comb begin
        acc_d = acc_q;
        flags_d = flags_q;
        wr_d.en = 1'b0;
        wr_d.addr = wr_q.addr;
        wr_d.data = wr_q.data;
        done_d = instr_valid_i;
        bad_d = (op == aalu_pkg::AALU_OP_BAD);
        case (op)
            aalu_pkg::AALU_OP_NONE,
            aalu_pkg::AALU_OP_NOP,
            aalu_pkg::AALU_OP_BAD: begin
                acc_d = acc_q;
            end
            default: begin
                if (to_reg) begin
                    wr_d.en = 1'b1; // RULE3
                    wr_d.addr = faddr;
                    wr_d.data = res;
                end else begin
                    acc_d = res; // RULE3
                end
                if (upd_cdc) begin
                    flags_d.carry = sum[DW]; // RULE16
                    flags_d.digit_carry_flag = low_sum[aalu_pkg::DIGIT_BIT];
                end
                if (upd_z) begin
                    flags_d.zero = (res == '0); // RULE16
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= aalu_pkg::ACC_RST;
            flags_q <= '0;
            wr_q <= '0;
            done_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            flags_q <= flags_d;
            wr_q <= wr_d;
            done_q <= done_d;
            bad_q <= bad_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign rf_we_o = wr_q.en;
    assign rf_waddr_o = wr_q.addr;
    assign rf_wdata_o = wr_q.data;
    assign acc_o = acc_q;
    assign carry_o = flags_q.carry;
    assign digit_carry_flag_o = flags_q.digit_carry_flag;
    assign zero_o = flags_q.zero;
    assign done_o = done_q;
    assign unsupported_o = bad_q;

endmodule

/* tb/aalu_core_assertions.sv */
// Port-level checker for the accumulator execution unit.
`timescale 1ns/100ps
module aalu_core_assertions (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Instruction side.
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    // Results.
    input wire logic rf_we_o,
    input wire logic [6:0] rf_waddr_o,
    input wire logic [7:0] rf_wdata_o,
    input wire logic [7:0] acc_o,
    input wire logic carry_o,
    input wire logic digit_carry_flag_o,
    input wire logic zero_o,
    input wire logic done_o,
    input wire logic unsupported_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic go, byte_op, setb, ncy;
    logic [7:0] lit;
    logic [6:0] fa;
    logic [2:0] flg, bs;
    logic [8:0] sum;
    assign go = instr_valid_i;
    assign lit = instr_i[7:0];
    assign fa = instr_i[6:0];
    assign bs = instr_i[9:7];
    assign setb = instr_i[10];
    assign flg = {carry_o, digit_carry_flag_o, zero_o};
    assign sum = {1'b0, acc_o} + {1'b0, lit};
    assign ncy = 5'({1'b0, acc_o[3:0]} + {1'b0, lit[3:0]}) > 5'h0f;
    assign byte_op = instr_i[13:12] == 2'h0 &&
        (instr_i[11:8] inside {4'h7, 4'h5, 4'h4, 4'h8});
    // ======================================================================
    // Assertions
    // ======================================================================
    done_set_a: assert property (go |=> done_o)
        else $error("done missing");
    done_clr_a: assert property (!go |=> !done_o)
        else $error("done without instruction");
    load_lit_a: assert property (go && instr_i[13:10] == 4'hc |=>
        acc_o == $past(lit) && $stable(flg)) else $error("load literal");
    add_lit_a: assert property (go && instr_i[13:9] == 5'h1f |=>
        {carry_o, acc_o} == $past(sum) && zero_o == (acc_o == 8'h00) &&
        digit_carry_flag_o == $past(ncy)) else $error("add literal");
    and_lit_a: assert property (go && instr_i[13:8] == 6'h39 |=>
        acc_o == ($past(acc_o) & $past(lit)) && zero_o == (acc_o == 8'h00)
        && $stable(carry_o)) else $error("and literal");
    or_lit_a: assert property (go && instr_i[13:8] == 6'h38 |=>
        acc_o == ($past(acc_o) | $past(lit)) && zero_o == (acc_o == 8'h00)
        && $stable(digit_carry_flag_o)) else $error("or literal");
    dest_acc_a: assert property (go && byte_op && !instr_i[7] |=>
        !rf_we_o) else $error("register written for acc destination");
    dest_reg_a: assert property (go && byte_op && instr_i[7] |=>
        rf_we_o && rf_waddr_o == $past(fa) && $stable(acc_o))
        else $error("register destination");
    store_reg_a: assert property (go && instr_i[13:7] == 7'h01 |=>
        rf_we_o && rf_wdata_o == $past(acc_o) && rf_waddr_o == $past(fa)
        && $stable(flg)) else $error("store");
    bit_op_a: assert property (go && instr_i[13:11] == 3'h2 |=>
        rf_we_o && rf_wdata_o[$past(bs)] == $past(setb) && $stable(flg))
        else $error("bit operation");
    nop_idle_a: assert property (go && instr_i[13:7] == 7'h00 &&
        instr_i[4:0] == 5'h00 |=> !rf_we_o && !unsupported_o &&
        $stable(acc_o) && $stable(flg)) else $error("nop changed state");
    cover property (go && instr_i[13:9] == 5'h1f ##1 carry_o);
    cover property (go && instr_i[13:7] == 7'h01);
    cover property (go && instr_i[13:11] == 3'h2 ##1 rf_we_o);
endmodule
bind aalu_core aalu_core_assertions u_chk (.clk_i, .nrst_i, .instr_valid_i,
    .instr_i, .rf_we_o, .rf_waddr_o, .rf_wdata_o, .acc_o, .carry_o,
    .digit_carry_flag_o, .zero_o, .done_o, .unsupported_o);

/* tb/aalu_rf_model.sv */
// Data register file model on the far side of the execution unit.
`timescale 1ns/100ps
module aalu_rf_model #(
    parameter logic [6:0] PORT_ADDR = 7'h05
) (
    // Clock.
    input wire logic clk_i,
    // Read port.
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o,
    output logic is_port_o,
    // Write port.
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 29 + 90);
        end
    end
    // The port's latch differs from the pins, so a wrong source shows.
    assign rdata_o = mem[raddr_i];
    assign is_port_o = (raddr_i == PORT_ADDR);
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the accumulator execution unit.
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0] pin_level_i = 8'h3c;
    logic [6:0] rf_raddr_o, rf_waddr_o;
    logic [7:0] rf_rdata_i, rf_wdata_o, acc_o;
    logic rf_is_port_i, rf_we_o, carry_o, digit_carry_flag_o, zero_o;
    logic done_o, unsupported_o;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] mem [128];
    logic [7:0] e_acc = 8'h00;
    logic [7:0] e_wd = 8'h00;
    logic [6:0] e_wa = 7'h00;
    logic [2:0] e_flg = 3'h0;

    always #12.5 clk_i = ~clk_i;

    aalu_core DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i),
        .rf_is_port_i(rf_is_port_i), .pin_level_i(pin_level_i),
        .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o),
        .acc_o(acc_o), .carry_o(carry_o),
        .digit_carry_flag_o(digit_carry_flag_o), .zero_o(zero_o),
        .done_o(done_o), .unsupported_o(unsupported_o));
    aalu_rf_model u_rf (.clk_i(clk_i), .raddr_i(rf_raddr_o),
        .rdata_o(rf_rdata_i), .is_port_o(rf_is_port_i), .we_i(rf_we_o),
        .waddr_i(rf_waddr_o), .wdata_i(rf_wdata_o));

    task tally_and_finish;
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Reference step, then one instruction, then a check of every result.
    task exec(input logic [13:0] w);
        logic [7:0] k, op, r, b;
        logic [6:0] f;
        logic [8:0] s;
        logic [1:0] to;
        logic zf, un;
        logic [28:0] got, exp;
        k = w[7:0];
        f = w[6:0];
        op = (f == 7'h05) ? pin_level_i : mem[f];
        {r, to, zf, un} = {op, 2'h0, 1'b0, 1'b0};
        casez (w)
            14'b00_0111_????_????, 14'b11_111?_????_????: begin
                b = w[13] ? k : op;
                s = {1'b0, e_acc} + {1'b0, b};
                r = s[7:0];
                e_flg[2] = s[8];
                e_flg[1] = ({1'b0, e_acc[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
                zf = 1'b1;
                to = w[13] ? 2'h1 : {w[7], ~w[7]};
            end
            14'b00_0101_????_????:
                {r, zf, to} = {e_acc & op, 1'b1, w[7], ~w[7]};
            14'b00_0100_????_????:
                {r, zf, to} = {e_acc | op, 1'b1, w[7], ~w[7]};
            14'b00_1000_????_????: {r, zf, to} = {op, 1'b1, w[7], ~w[7]};
            14'b00_0000_1???_????: {r, to} = {e_acc, 2'h2};
            14'b00_0000_0??0_0000: to = 2'h0;
            14'b01_00??_????_????: {r, to} = {op & ~(8'h01 << w[9:7]), 2'h2};
            14'b01_01??_????_????: {r, to} = {op | (8'h01 << w[9:7]), 2'h2};
            14'b11_1001_????_????: {r, zf, to} = {e_acc & k, 1'b1, 2'h1};
            14'b11_1000_????_????: {r, zf, to} = {e_acc | k, 1'b1, 2'h1};
            14'b11_00??_????_????: {r, to} = {k, 2'h1};
            default: un = 1'b1;
        endcase
        if (zf)
            e_flg[0] = (r == 8'h00);
        if (to == 2'h1)
            e_acc = r;
        if (to == 2'h2)
            {mem[f], e_wa, e_wd} = {r, f, r};
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
        got = {acc_o, carry_o, digit_carry_flag_o, zero_o, done_o,
            unsupported_o, rf_we_o, rf_waddr_o, rf_wdata_o};
        exp = {e_acc, e_flg, 1'b1, un, to == 2'h2, e_wa, e_wd};
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 128; i++)
            mem[i] = u_rf.mem[i];
        exec(14'h30a5);
        exec(14'h3300);
        exec(14'h3eff);
        exec(14'h3f01);
        exec(14'h3e08);
        exec(14'h3e08);
        exec(14'h39f0);
        exec(14'h390f);
        exec(14'h3800);
        exec(14'h3881);
        exec(14'h0080);
        exec(14'h00ff);
        exec(14'h0710);
        exec(14'h07ff);
        exec(14'h0520);
        exec(14'h05a0);
        exec(14'h0430);
        exec(14'h04b0);
        exec(14'h0840);
        exec(14'h3000);
        exec(14'h00c1);
        exec(14'h3055);
        exec(14'h08c1);
        for (int b = 0; b < 8; b++) begin
            exec({4'h4, b[2:0], 7'h22});
            exec({4'h5, b[2:0], 7'h23});
        end
        exec(14'h0805);
        exec({4'h5, 3'h0, 7'h05});
        for (int x = 0; x < 4; x++)
            exec({7'h00, x[1:0], 5'h00});
        // Back to back: the move must see the store of the cycle before.
        @(posedge clk_i);
        instr_i <= 14'h00a2;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_i <= 14'h0822;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
        {mem[7'h22], e_wa, e_wd} = {e_acc, 7'h22, e_acc};
        e_flg[0] = (e_acc == 8'h00);
        comparisons++;
        if ({acc_o, zero_o, rf_we_o} !==
            {e_acc, e_flg[0], 1'b0}) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time,
                {acc_o, zero_o, rf_we_o}, {e_acc, e_flg[0], 1'b0});
        end
        exec(14'h2abc);
        exec(14'h3400);
        tally_and_finish();
    end
endmodule
